// File: hw/gsrp_port.v
// serial readout port of a rate sensor: 16-clock full-duplex frames
// assumes the converter answers conversion requests on the smp_* stream
// and that the serial host drives cs_n_i, sclk_i and din_i asynchronously
//
// Contract
// - output a zero at chip select fall, a second at first falling edge
// - then shift two source bits and twelve data bits on falling edges
// - release the serial output after the sixteenth falling edge
// - input bit 15 set loads control settings; clear leaves them
// - input bits 11:10 choose rate, temperature, first or second aux
// - input bit 4 chooses two's complement or offset binary coding
// - rate field zero at rest in two's complement
// - rate field 2048 at rest in offset binary
// - temperature field centred on zero or 2048 by coding
// - aux fields centred on zero or 2048 by coding
// - third and fourth output bits echo the source code, high first
// - chip select high keeps output released and ignores clock, input
// - input captured on falling edges; only full frames apply writes
// - hold from chip select fall to 14th edge; short frames keep data
// - read frames keep settings; next output follows them
`timescale 1ns/1ps
`include "gsrp_defines.vh"
module gsrp_port #(
  parameter DW = `GSRP_DATA_W
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rstn_i,
  // serial link pins
  input  wire          cs_n_i,
  input  wire          sclk_i,
  input  wire          din_i,
  output reg           dout_o,
  output reg           dout_oe_o,
  // converter side
  output reg           conv_req_o,
  output reg  [1:0]    conv_src_o,
  output reg           hold_o,
  input  wire          smp_valid_i,
  input  wire [DW-1:0] smp_data_i,
  output wire          smp_ready_o,
  // settings in force
  output reg  [1:0]    cfg_src_o,
  output reg           cfg_code_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [2:0] cs_sync_reg;
  reg [2:0] sclk_sync_reg;
  reg [1:0] din_sync_reg;

  // stage 0 is read only by stage 1; stage 2 serves edge detection
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h7;
      din_sync_reg  <= 2'h0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      din_sync_reg  <= {din_sync_reg[0], din_i};
    end
  end

  wire cs_low  = ~cs_sync_reg[1];
  wire cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
  wire cs_rise = ~cs_sync_reg[2] & cs_sync_reg[1];
  // clock edges count only inside a frame
  wire sck_fall = cs_low & ~cs_fall &
                  sclk_sync_reg[2] & ~sclk_sync_reg[1];
  wire din_s    = din_sync_reg[1];

  // ****************************************************************
  // sample buffer
  // ****************************************************************
  wire          buf_valid;
  wire [DW-1:0] buf_data;
  reg           pend_valid_reg;
  reg  [DW-1:0] pend_reg;
  // accept a sample only while holding, one per frame
  wire          buf_take = hold_o & ~pend_valid_reg;

  gsrp_buf #(
    .W(DW)
  ) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (smp_valid_i),
    .in_data_i   (smp_data_i),
    .in_ready_o  (smp_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (buf_take)
  );

  // ****************************************************************
  // frame state
  // ****************************************************************
  reg [`GSRP_CNT_W-1:0]  cnt_reg;
  reg [`GSRP_WORD_W-1:0] rx_reg;
  reg [1:0]              frm_src_reg;
  reg                    frm_code_reg;
  reg [DW-1:0]           shown_reg;
  reg [1:0]              shown_src_reg;

  wire [`GSRP_CNT_W-1:0]  cnt_next = cnt_reg + 1'b1;
  wire [`GSRP_WORD_W-1:0] rx_next  = {rx_reg[`GSRP_WORD_W-2:0], din_s};
  wire                    last_edge = sck_fall &
                                      (cnt_next == `GSRP_FRAME_BITS);
  // outgoing word: two zeros, source echo, data, msb first
  wire [`GSRP_WORD_W-1:0] tx_word = {`GSRP_LEAD_ZEROS, shown_src_reg,
                                     shown_reg};
  // offset binary is two's complement with the top bit flipped
  wire [DW-1:0] coded = (frm_code_reg == `GSRP_CODE_OFFS) ?
                        {~pend_reg[`GSRP_DATA_MSB],
                         pend_reg[`GSRP_DATA_MSB-1:0]} :
                        pend_reg;

  // edge counter and receive shifter, cleared at each frame start
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= {`GSRP_CNT_W{1'b0}};
      rx_reg  <= {`GSRP_WORD_W{1'b0}};
    end else if (cs_fall) begin
      cnt_reg <= {`GSRP_CNT_W{1'b0}};
      rx_reg  <= {`GSRP_WORD_W{1'b0}};
    end else if (sck_fall && cnt_reg != `GSRP_FRAME_BITS) begin
      cnt_reg <= cnt_next;
      rx_reg  <= rx_next;
    end
  end

  // ****************************************************************
  // control settings
  // ****************************************************************
  // a write lands only on the sixteenth edge, so short frames do nothing
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_src_o  <= `GSRP_SRC_RATE;
      cfg_code_o <= `GSRP_CODE_TWOS;
    end else if (last_edge && cnt_reg != `GSRP_FRAME_BITS &&
                 rx_next[`GSRP_WR_BIT]) begin
      cfg_src_o  <= rx_next[`GSRP_SRC_HI:`GSRP_SRC_LO];
      cfg_code_o <= rx_next[`GSRP_CODE_BIT];
    end
  end

  // ****************************************************************
  // conversion control
  // ****************************************************************
  // settings are frozen per frame so a write mid-frame cannot mix them
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_req_o   <= 1'b0;
      conv_src_o   <= `GSRP_SRC_RATE;
      hold_o       <= 1'b0;
      frm_src_reg  <= `GSRP_SRC_RATE;
      frm_code_reg <= `GSRP_CODE_TWOS;
    end else begin
      conv_req_o <= cs_fall;
      if (cs_fall) begin
        hold_o       <= 1'b1;
        conv_src_o   <= cfg_src_o;
        frm_src_reg  <= cfg_src_o;
        frm_code_reg <= cfg_code_o;
      end else if ((sck_fall && cnt_next == `GSRP_TRACK_EDGE) ||
                   cs_rise) begin
        hold_o <= 1'b0;
      end
    end
  end

  // pending sample commits only when the frame completes
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_valid_reg <= 1'b0;
      pend_reg       <= `GSRP_DATA_RST;
      shown_reg      <= `GSRP_DATA_RST;
      shown_src_reg  <= `GSRP_SRC_RATE;
    end else begin
      if (cs_fall) begin
        pend_valid_reg <= 1'b0;
      end else if (buf_take && buf_valid) begin
        pend_valid_reg <= 1'b1;
        pend_reg       <= buf_data;
      end
      if (last_edge && cnt_reg != `GSRP_FRAME_BITS && pend_valid_reg) begin
        shown_reg     <= coded;
        shown_src_reg <= frm_src_reg;
      end
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  // driven from chip select fall until the sixteenth edge or cs rise
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (cs_fall) begin
      dout_o    <= tx_word[`GSRP_WORD_W-1];
      dout_oe_o <= 1'b1;
    end else if (!cs_low) begin
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else if (sck_fall && cnt_reg != `GSRP_FRAME_BITS) begin
      if (cnt_next == `GSRP_FRAME_BITS) begin
        dout_o    <= 1'b0;
        dout_oe_o <= 1'b0;
      end else begin
        // first edge gives the second zero, then source and data
        dout_o <= tx_word[`GSRP_WORD_W-1-cnt_next];
      end
    end
  end

endmodule // gsrp_port

// File: shared/gsrp_defines.vh
// constants for the gyro serial readout port
// assumes inclusion by bare name from the top design file of the port; the buffer file does not include it
`ifndef GSRP_DEFINES_VH
`define GSRP_DEFINES_VH

// ****************************************************************
// frame layout
// ****************************************************************
`define GSRP_FRAME_BITS  5'h10
`define GSRP_TRACK_EDGE  5'h0e
`define GSRP_CNT_W       5
`define GSRP_WORD_W      16
`define GSRP_DATA_W      12
`define GSRP_DATA_MSB    11

// ****************************************************************
// control word fields
// ****************************************************************
`define GSRP_WR_BIT      15
`define GSRP_SRC_HI      11
`define GSRP_SRC_LO      10
`define GSRP_CODE_BIT    4

// ****************************************************************
// source codes and reset values
// ****************************************************************
`define GSRP_SRC_RATE    2'h0
`define GSRP_SRC_TEMP    2'h1
`define GSRP_SRC_AUX1    2'h2
`define GSRP_SRC_AUX2    2'h3
`define GSRP_CODE_TWOS   1'b0
`define GSRP_CODE_OFFS   1'b1
`define GSRP_LEAD_ZEROS  2'h0
`define GSRP_DATA_RST    12'h000

`endif

// File: hw/gsrp_buf.v
// two-entry buffer with valid and ready on both sides
// assumes a single clock domain; full and empty are registered
`timescale 1ns/1ps
module gsrp_buf #(
  parameter W = 12
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rstn_i,
  // filling side
  input  wire         in_valid_i,
  input  wire [W-1:0] in_data_i,
  output wire         in_ready_o,
  // draining side
  output wire         out_valid_o,
  output wire [W-1:0] out_data_o,
  input  wire         out_ready_i
);

  reg [W-1:0] mem_reg [0:1];
  reg         wp_reg;
  reg         rp_reg;
  reg         room_reg;
  reg         empty_reg;

  wire push = in_valid_i & room_reg;
  wire pop  = out_ready_i & ~empty_reg;

  // ready comes straight from a flop so the top output needs no gate
  assign in_ready_o  = room_reg;
  assign out_valid_o = ~empty_reg;
  assign out_data_o  = mem_reg[rp_reg];

  // storage carries no reset; only pointers and flags need one
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  // pointers and occupancy flags
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_reg    <= 1'b0;
      rp_reg    <= 1'b0;
      room_reg  <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      // pushing onto one entry fills both; pointers equal means empty
      if (push & ~pop) begin
        empty_reg <= 1'b0;
        room_reg  <= (wp_reg == rp_reg);
      end else if (pop & ~push) begin
        room_reg  <= 1'b1;
        empty_reg <= (wp_reg == (~rp_reg));
      end
    end
  end

endmodule // gsrp_buf

// File: tb/gsrp_port_properties.sv
// pin checker for the gsrp readout port
// assumes binding onto gsrp_port; sees its ports only
`timescale 1ns/1ps
module gsrp_port_properties #(
  parameter DW = 12
) (
  // clock and reset
  input wire          clk_i,
  input wire          rstn_i,
  // serial pins
  input wire          cs_n_i,
  input wire          sclk_i,
  input wire          din_i,
  input wire          dout_o,
  input wire          dout_oe_o,
  // converter side and settings
  input wire          conv_req_o,
  input wire [1:0]    conv_src_o,
  input wire          hold_o,
  input wire          smp_valid_i,
  input wire [DW-1:0] smp_data_i,
  input wire          smp_ready_o,
  input wire [1:0]    cfg_src_o,
  input wire          cfg_code_o
);
  reg [4:0] fall_cnt;
  reg       sclk_q;
  // ****************************************************************
  // falls per frame
  // ****************************************************************
  // raw pins; the repeat counts below absorb the sync lag
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fall_cnt <= 5'h00;
      sclk_q   <= 1'b1;
    end else begin
      sclk_q <= sclk_i;
      if (cs_n_i)
        fall_cnt <= 5'h00;
      else if (sclk_q && !sclk_i)
        fall_cnt <= fall_cnt + 5'h01;
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_idle_release: assert property (cs_n_i [*5] |-> !dout_oe_o)
    else $error("output driven while deselected");
  a_lead_zero: assert property (
    $fell(cs_n_i) |-> ##[2:4] (dout_oe_o && !dout_o))
    else $error("no leading zero after select");
  a_hold_start: assert property (
    $fell(cs_n_i) |-> ##[2:4] (hold_o && conv_req_o))
    else $error("no hold or conversion at select");
  a_req_source: assert property (
    conv_req_o |-> conv_src_o == cfg_src_o)
    else $error("conversion source differs from setting");
  a_cfg_frame: assert property (
    (!$stable(cfg_src_o) || !$stable(cfg_code_o)) |-> fall_cnt == 5'h10)
    else $error("settings changed outside full frame");
  a_oe_release: assert property (
    (fall_cnt == 5'h10) [*5] |-> !dout_oe_o)
    else $error("output kept after last fall");
  a_hold_end: assert property ((fall_cnt == 5'h0e) [*5] |-> !hold_o)
    else $error("hold kept after fourteenth fall");
  a_oe_drive: assert property (
    (!cs_n_i && fall_cnt < 5'h10) [*5] |-> dout_oe_o)
    else $error("output released inside frame");
  // main scenarios reached
  c_frame: cover property ($fell(cs_n_i));
  c_full: cover property (fall_cnt == 5'h10);
  c_stall: cover property (!smp_ready_o);
endmodule // gsrp_port_properties

bind gsrp_port gsrp_port_properties #(.DW(DW)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
  .din_i(din_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .conv_req_o(conv_req_o), .conv_src_o(conv_src_o), .hold_o(hold_o),
  .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
  .smp_ready_o(smp_ready_o), .cfg_src_o(cfg_src_o),
  .cfg_code_o(cfg_code_o));

// File: tb/gsrp_host_model.sv
// serial host model: clock idles high, words msb first
// assumes clk_i is the bench clock; steps land 1 ns after its edges
`timescale 1ns/1ps
module gsrp_host_model (
  // bench clock and returned line
  input  wire clk_i,
  input  wire miso_i,
  // master pins
  output reg  cs_n_o,
  output reg  sclk_o,
  output reg  din_o
);
  // idle: deselected, clock high
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o  = 1'b0;
  end
  task hw(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // n falls of 25 clocks; quiet keeps select high
  task xfer(input [15:0] w, input [4:0] n, input quiet,
            output [15:0] rd);
    integer    i;
    reg [15:0] wd;
    begin
      wd = (w | 16'h0300) & 16'hbfdf;
      rd = 16'h0000;
      hw(1);
      cs_n_o = quiet;
      din_o  = wd[15];
      hw(13);
      for (i = 0; i < n; i = i + 1) begin
        rd     = {rd[14:0], miso_i};
        sclk_o = 1'b0;
        hw(12);
        sclk_o = 1'b1;
        wd     = wd << 1;
        din_o  = wd[15];
        hw(13);
      end
      cs_n_o = 1'b1;
      hw(6);
    end
  endtask
endmodule // gsrp_host_model

// File: tb/testbench.sv
// self-checking bench for the gsrp readout port
// assumes the host model and the bound pin checker
`timescale 1ns/1ps
module testbench;
  reg         clk_i;
  reg         rstn_i;
  reg         smp_valid_i;
  reg  [11:0] smp_data_i;
  reg  [15:0] junk;
  reg  [1:0]  src;
  reg         code;
  reg  [43:0] rows [0:7];
  integer     miscompares, total_checks, cycles, r;
  wire        cs_n, sclk, din, dout_o, dout_oe_o, miso;
  wire        conv_req_o, hold_o, smp_ready_o, cfg_code_o;
  wire [1:0]  conv_src_o, cfg_src_o;
  // released line shows the inverse, never a held bit
  assign miso = dout_oe_o ? dout_o : ~dout_o;
  gsrp_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .conv_req_o(conv_req_o), .conv_src_o(conv_src_o), .hold_o(hold_o),
    .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
    .smp_ready_o(smp_ready_o), .cfg_src_o(cfg_src_o),
    .cfg_code_o(cfg_code_o));
  gsrp_host_model host (.clk_i(clk_i), .miso_i(miso), .cs_n_o(cs_n),
    .sclk_o(sclk), .din_o(din));
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // sample held until an edge sees ready
  task push(input [11:0] d);
    begin
      smp_valid_i = 1'b1;
      smp_data_i  = d;
      while (smp_ready_o !== 1'b1) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      #1;
      smp_valid_i = 1'b0;
      // one idle edge so a following push never re-raises valid at once
      @(posedge clk_i);
      #1;
    end
  endtask
  // full frame; settings follow only writes
  task run(input [15:0] w, input [15:0] e, input string nm);
    reg [15:0] rd;
    begin
      host.xfer(w, 5'h10, 1'b0, rd);
      check(nm, rd, e);
      if (w[15]) begin
        src  = w[11:10];
        code = w[4];
      end
      check("config", {13'h0, cfg_src_o, cfg_code_o},
            {13'h0, src, code});
      $display("test %0s done", nm);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard, about three and a half times the planned run
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial begin
    rstn_i       = 1'b0;
    smp_valid_i  = 1'b0;
    smp_data_i   = 12'h000;
    miscompares  = 0;
    total_checks = 0;
    cycles       = 0;
    src          = 2'h0;
    code         = 1'b0;
    // write word, sample, readback of this frame; the readback is the
    // previous frame's sample, coded and tagged by the settings in force
    // when that previous frame began
    rows[0] = {16'h8000, 12'h000, 16'h0000};
    rows[1] = {16'h8010, 12'h333, 16'h0000};
    rows[2] = {16'h8410, 12'hccd, 16'h0333};
    rows[3] = {16'h8800, 12'h000, 16'h04cd};
    rows[4] = {16'h8c10, 12'h000, 16'h1800};
    rows[5] = {16'h0000, 12'h7ff, 16'h2000};
    rows[6] = {16'h0010, 12'h001, 16'h3fff};
    rows[7] = {16'h8400, 12'h000, 16'h3801};
    repeat (8) @(posedge clk_i);
    check("reset", {9'h0, dout_oe_o, conv_req_o, hold_o, smp_ready_o,
          cfg_src_o, cfg_code_o}, 16'h0008);
    #1;
    rstn_i = 1'b1;
    host.hw(5);
    for (r = 0; r < 8; r = r + 1) begin
      push(rows[r][27:16]);
      run(rows[r][43:28], rows[r][15:0], "row");
    end
    // short write frame that swallows a sample, then deselected clocks
    push(12'h5a5);
    host.xfer(16'h8c10, 5'h0a, 1'b0, junk);
    host.xfer(16'h8c10, 5'h10, 1'b1, junk);
    push(12'h000);
    run(16'h0000, 16'h3800, "short");
    // fill the buffer until it refuses, then drain it
    push(12'h123);
    push(12'h456);
    host.hw(2);
    check("ready", {15'h0, smp_ready_o}, 16'h0000);
    run(16'h0000, 16'h1000, "stall");
    run(16'h0000, 16'h1123, "drain");
    run(16'h0000, 16'h1456, "empty");
    summarize;
  end
endmodule // testbench
